// File: verilog/i2cms_pkg.sv
// Shared constants and state encoding for the I2C master sequencer
package i2cms_pkg;

  localparam int RATE_W = 7;
  localparam int DATA_W = 8;
  localparam int BITS_W = 4;
  localparam int SYNC_STAGES = 3;

  // Reload value fields
  localparam int RELOAD_FULL_HI = 6;
  localparam int RELOAD_SHORT_HI = 5;

  // Bit counter landmarks
  localparam logic [BITS_W-1:0] BIT_FIRST = 4'h0;
  localparam logic [BITS_W-1:0] BIT_EIGHTH = 4'h7;
  localparam logic [BITS_W-1:0] BIT_ACK = 4'h8;

  // Values after reset
  localparam logic [RATE_W-1:0] RATE_RESET = 7'h00;
  localparam logic [DATA_W-1:0] BUFFER_RESET = 8'h00;
  localparam logic [1:0] LINES_RESET = 2'h3;

  // Gray-coded sequence states
  typedef enum logic [3:0] {
    I2CMS_IDLE = 4'h0,
    I2CMS_START_WAIT = 4'h1,
    I2CMS_START_HOLD = 4'h3,
    I2CMS_RS_LOW = 4'h2,
    I2CMS_RS_RISE = 4'h6,
    I2CMS_RS_HIGH = 4'h7,
    I2CMS_RS_SDA = 4'h5,
    I2CMS_TX_LOW = 4'h4,
    I2CMS_TX_HIGH = 4'hc,
    I2CMS_ACK_LOW = 4'hd,
    I2CMS_ACK_HIGH = 4'hf,
    I2CMS_STOP_LOW = 4'he,
    I2CMS_STOP_RISE = 4'ha,
    I2CMS_STOP_REL = 4'hb
  } i2cms_state_t;

endpackage

// File: verilog/i2cms_rate_if.sv
// Link between the sequencer and its rate generator
`timescale 1ns/1ns
interface i2cms_rate_if;
  import i2cms_pkg::*;
  logic load;
  logic [RATE_W-1:0] value;
  logic timeout;
  modport ctl (output load, output value, input timeout);
  modport gen (input load, input value, output timeout);
endinterface

// File: verilog/i2cms_sync.sv
// Three-stage synchroniser with agreement filter for the bus lines
`timescale 1ns/1ns
module i2cms_sync
  import i2cms_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic [1:0] raw,
  output logic [1:0] clean
);
  logic [1:0] stage1;
  logic [1:0] stage2;
  logic [1:0] stage3;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1 <= LINES_RESET;
      stage2 <= LINES_RESET;
      stage3 <= LINES_RESET;
    end else if (clock_enable) begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Each line updates once the last two stages agree
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      clean <= LINES_RESET;
    end else if (clock_enable) begin
      for (int i = 0; i < 2; i++) begin
        if (stage2[i] == stage3[i]) begin
          clean[i] <= stage3[i];
        end
      end
    end
  end
endmodule

// File: verilog/i2cms_rate_gen.sv
// Reloadable down-counter that marks one rate period
`timescale 1ns/1ns
module i2cms_rate_gen
  import i2cms_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic module_enable,
  i2cms_rate_if.gen rate
);
  logic [RATE_W-1:0] count;
  logic active;

  // Counts down to zero once per load, then stops until reloaded
  assign rate.timeout = active && (count == RATE_RESET);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= RATE_RESET;
      active <= 1'b0;
    end else if (clock_enable) begin
      if (!module_enable) begin
        active <= 1'b0;
        count <= RATE_RESET;
      end else if (rate.load) begin
        count <= rate.value;
        active <= 1'b1;
      end else if (rate.timeout) begin
        active <= 1'b0;
      end else if (active) begin
        count <= count - 7'h01;
      end
    end
  end
endmodule

// File: verilog/i2cms_sequencer.sv
// I2C master condition sequencer: start, restart, byte send, acknowledge, stop
`timescale 1ns/1ns
module i2cms_sequencer
  import i2cms_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic module_enable,
  input wire logic [RATE_W-1:0] rate_reload_register,
  input wire logic begin_cond_set,
  input wire logic restart_set,
  input wire logic halt_cond_set,
  input wire logic acknowledge_sequence_set,
  input wire logic acknowledge_value_bit,
  input wire logic buffer_write,
  input wire logic [DATA_W-1:0] buffer_write_data,
  input wire logic port_event_clear,
  input wire logic collision_clear,
  input wire logic write_collide_clear,
  input wire logic sleep_mode,
  input wire logic interrupt_enable,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic begin_cond_trigger,
  output logic restart_trigger,
  output logic halt_cond_trigger,
  output logic acknowledge_sequence_trigger,
  output logic [DATA_W-1:0] transfer_buffer,
  output logic buffer_full_flag,
  output logic acknowledge_received_status,
  output logic port_event_flag,
  output logic collision_flag,
  output logic write_collide_flag,
  output logic begin_noted,
  output logic halt_detected,
  output logic wake_request
);
  i2cms_rate_if rate ();
  i2cms_state_t state;
  logic [1:0] lines;
  logic scl_s;
  logic sda_s;
  logic scl_prev;
  logic sda_prev;
  logic scl_low;
  logic sda_low;
  logic armed;
  logic [BITS_W-1:0] bit_cnt;
  logic [DATA_W-1:0] shift;
  logic rate_load;
  logic [RATE_W-1:0] rate_value;
  logic tmo;
  logic any_trigger;
  logic buffer_ok;
  logic collide;
  logic event_set;
  logic start_seen;
  logic stop_seen;
  logic expect_one;

  i2cms_sync u_sync (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .raw({scl_in, sda_in}),
    .clean(lines)
  );

  i2cms_rate_gen u_rate (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .module_enable(module_enable),
    .rate(rate.gen)
  );

  assign scl_s = lines[1];
  assign sda_s = lines[0];
  assign rate.load = rate_load;
  assign rate.value = rate_value;
  assign tmo = rate.timeout;

  // Open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_low;
  assign sda_oe = sda_low;

  function automatic logic [RATE_W-1:0] reload_full(input logic [RATE_W-1:0] r);
    reload_full = r[RELOAD_FULL_HI:0];
  endfunction

  function automatic logic [RATE_W-1:0] reload_short(input logic [RATE_W-1:0] r);
    reload_short = {1'b0, r[RELOAD_SHORT_HI:0]};
  endfunction

  assign any_trigger = begin_cond_trigger | restart_trigger | halt_cond_trigger
                       | acknowledge_sequence_trigger;
  // No queueing: the buffer is writable only when the sequencer rests
  assign buffer_ok = (state == I2CMS_IDLE) && !any_trigger;
  assign expect_one = (bit_cnt < BIT_ACK) && shift[DATA_W-1];

  // Line condition detectors on the filtered levels
  assign start_seen = scl_s && scl_prev && sda_prev && !sda_s;
  assign stop_seen = scl_s && scl_prev && !sda_prev && sda_s;

  // Arbitration losses in every sequence
  always_comb begin
    collide = 1'b0;
    unique case (state)
      I2CMS_IDLE: collide = begin_cond_trigger && !(scl_s && sda_s);
      I2CMS_START_WAIT: collide = !scl_s;
      I2CMS_RS_LOW: collide = armed && tmo && !sda_s;
      I2CMS_RS_RISE: collide = !armed && scl_s && !sda_s;
      I2CMS_RS_HIGH: collide = !scl_s;
      I2CMS_TX_HIGH: collide = armed && scl_s && expect_one && !sda_s;
      I2CMS_ACK_HIGH: collide = armed && scl_s && acknowledge_value_bit && !sda_s;
      I2CMS_STOP_RISE: collide = armed && !scl_s;
      I2CMS_STOP_REL: collide = !armed && !scl_s;
      default: collide = 1'b0;
    endcase
  end

  // Event flag sources
  always_comb begin
    event_set = 1'b0;
    if (module_enable) begin
      unique case (state)
        I2CMS_START_HOLD: event_set = tmo;
        I2CMS_RS_SDA: event_set = tmo;
        I2CMS_TX_HIGH: event_set = armed && tmo && (bit_cnt == BIT_ACK);
        I2CMS_ACK_HIGH: event_set = armed && tmo;
        I2CMS_STOP_REL: event_set = armed && tmo;
        default: event_set = 1'b0;
      endcase
      if (collision_flag && stop_seen) begin
        event_set = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else if (clock_enable) begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  // Sequencer: states, line drive, triggers, rate loads and shifting
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= I2CMS_IDLE;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      armed <= 1'b0;
      bit_cnt <= BIT_FIRST;
      shift <= BUFFER_RESET;
      transfer_buffer <= BUFFER_RESET;
      rate_load <= 1'b0;
      rate_value <= RATE_RESET;
      begin_cond_trigger <= 1'b0;
      restart_trigger <= 1'b0;
      halt_cond_trigger <= 1'b0;
      acknowledge_sequence_trigger <= 1'b0;
    end else if (clock_enable) begin
      rate_load <= 1'b0;
      if (!module_enable) begin
        state <= I2CMS_IDLE;
        scl_low <= 1'b0;
        sda_low <= 1'b0;
        armed <= 1'b0;
        begin_cond_trigger <= 1'b0;
        restart_trigger <= 1'b0;
        halt_cond_trigger <= 1'b0;
        acknowledge_sequence_trigger <= 1'b0;
      end else if (collide) begin
        state <= I2CMS_IDLE;
        scl_low <= 1'b0;
        sda_low <= 1'b0;
        armed <= 1'b0;
        bit_cnt <= BIT_FIRST;
        begin_cond_trigger <= 1'b0;
        restart_trigger <= 1'b0;
        halt_cond_trigger <= 1'b0;
        acknowledge_sequence_trigger <= 1'b0;
      end else begin
        unique case (state)
          I2CMS_IDLE: begin
            armed <= 1'b0;
            if (begin_cond_trigger) begin
              rate_load <= 1'b1;
              rate_value <= reload_full(rate_reload_register);
              state <= I2CMS_START_WAIT;
            end else if (restart_trigger) begin
              scl_low <= 1'b1;
              state <= I2CMS_RS_LOW;
            end else if (acknowledge_sequence_trigger) begin
              scl_low <= 1'b1;
              sda_low <= !acknowledge_value_bit;
              rate_load <= 1'b1;
              rate_value <= reload_full(rate_reload_register);
              state <= I2CMS_ACK_LOW;
            end else if (halt_cond_trigger) begin
              sda_low <= 1'b1;
              state <= I2CMS_STOP_LOW;
            end else if (buffer_write) begin
              transfer_buffer <= buffer_write_data;
              shift <= buffer_write_data;
              bit_cnt <= BIT_FIRST;
              scl_low <= 1'b1;
              rate_load <= 1'b1;
              rate_value <= reload_full(rate_reload_register);
              state <= I2CMS_TX_LOW;
            end else begin
              begin_cond_trigger <= begin_cond_set;
              restart_trigger <= restart_set;
              halt_cond_trigger <= halt_cond_set;
              acknowledge_sequence_trigger <= acknowledge_sequence_set;
            end
          end
          I2CMS_START_WAIT: begin
            if (tmo || !sda_s) begin
              sda_low <= 1'b1;
              rate_load <= 1'b1;
              rate_value <= reload_full(rate_reload_register);
              state <= I2CMS_START_HOLD;
            end
          end
          I2CMS_START_HOLD: begin
            if (tmo) begin
              scl_low <= 1'b1;
              begin_cond_trigger <= 1'b0;
              state <= I2CMS_IDLE;
            end
          end
          I2CMS_RS_LOW: begin
            if (!armed && !scl_s) begin
              rate_load <= 1'b1;
              rate_value <= reload_short(rate_reload_register);
              sda_low <= 1'b0;
              armed <= 1'b1;
            end else if (armed && tmo) begin
              scl_low <= 1'b0;
              armed <= 1'b0;
              state <= I2CMS_RS_RISE;
            end
          end
          I2CMS_RS_RISE: begin
            if (scl_s) begin
              rate_load <= 1'b1;
              rate_value <= reload_full(rate_reload_register);
              state <= I2CMS_RS_HIGH;
            end
          end
          I2CMS_RS_HIGH: begin
            if (tmo) begin
              sda_low <= 1'b1;
              rate_load <= 1'b1;
              rate_value <= reload_full(rate_reload_register);
              state <= I2CMS_RS_SDA;
            end
          end
          I2CMS_RS_SDA: begin
            if (tmo) begin
              restart_trigger <= 1'b0;
              state <= I2CMS_IDLE;
            end
          end
          I2CMS_TX_LOW: begin
            if (!armed) begin
              armed <= 1'b1;
              sda_low <= (bit_cnt < BIT_ACK) ? !shift[DATA_W-1] : 1'b0;
            end else if (tmo) begin
              scl_low <= 1'b0;
              armed <= 1'b0;
              state <= I2CMS_TX_HIGH;
            end
          end
          I2CMS_TX_HIGH: begin
            if (!armed && scl_s) begin
              rate_load <= 1'b1;
              rate_value <= reload_full(rate_reload_register);
              armed <= 1'b1;
            end else if (armed && tmo) begin
              scl_low <= 1'b1;
              armed <= 1'b0;
              if (bit_cnt == BIT_ACK) begin
                state <= I2CMS_IDLE;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
                shift <= {shift[DATA_W-2:0], 1'b0};
                rate_load <= 1'b1;
                rate_value <= reload_full(rate_reload_register);
                state <= I2CMS_TX_LOW;
              end
            end
          end
          I2CMS_ACK_LOW: begin
            if (tmo) begin
              scl_low <= 1'b0;
              armed <= 1'b0;
              state <= I2CMS_ACK_HIGH;
            end
          end
          I2CMS_ACK_HIGH: begin
            if (!armed && scl_s) begin
              rate_load <= 1'b1;
              rate_value <= reload_full(rate_reload_register);
              armed <= 1'b1;
            end else if (armed && tmo) begin
              scl_low <= 1'b1;
              acknowledge_sequence_trigger <= 1'b0;
              state <= I2CMS_IDLE;
            end
          end
          I2CMS_STOP_LOW: begin
            if (!armed && !sda_s) begin
              rate_load <= 1'b1;
              rate_value <= reload_full(rate_reload_register);
              armed <= 1'b1;
            end else if (armed && tmo) begin
              scl_low <= 1'b0;
              armed <= 1'b0;
              state <= I2CMS_STOP_RISE;
            end
          end
          I2CMS_STOP_RISE: begin
            if (!armed && scl_s) begin
              rate_load <= 1'b1;
              rate_value <= reload_full(rate_reload_register);
              armed <= 1'b1;
            end else if (armed && tmo) begin
              sda_low <= 1'b0;
              armed <= 1'b0;
              state <= I2CMS_STOP_REL;
            end
          end
          I2CMS_STOP_REL: begin
            if (!armed && sda_s && scl_s) begin
              rate_load <= 1'b1;
              rate_value <= reload_full(rate_reload_register);
              armed <= 1'b1;
            end else if (armed && tmo) begin
              halt_cond_trigger <= 1'b0;
              armed <= 1'b0;
              state <= I2CMS_IDLE;
            end
          end
          default: state <= I2CMS_IDLE;
        endcase
      end
    end
  end

  // Buffer-full: set by an accepted write, cleared at eighth fall, collision or disable
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      buffer_full_flag <= 1'b0;
    end else if (clock_enable) begin
      if (module_enable && buffer_write && buffer_ok) begin
        buffer_full_flag <= 1'b1;
      end else if (!module_enable || collide) begin
        buffer_full_flag <= 1'b0;
      end else if (state == I2CMS_TX_HIGH && armed && tmo && bit_cnt == BIT_EIGHTH) begin
        buffer_full_flag <= 1'b0;
      end
    end
  end

  // Slave acknowledge level captured at the ninth falling edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      acknowledge_received_status <= 1'b0;
    end else if (clock_enable) begin
      if (state == I2CMS_TX_HIGH && armed && tmo && bit_cnt == BIT_ACK && !collide) begin
        acknowledge_received_status <= sda_s;
      end
    end
  end

  // Sticky flags: a set in the cycle of a clear wins
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      port_event_flag <= 1'b0;
      collision_flag <= 1'b0;
      write_collide_flag <= 1'b0;
    end else if (clock_enable) begin
      port_event_flag <= event_set || (port_event_flag && !port_event_clear);
      collision_flag <= (module_enable && collide)
                        || (collision_flag && !collision_clear);
      write_collide_flag <= (module_enable && buffer_write && !buffer_ok)
                            || (write_collide_flag && !write_collide_clear);
    end
  end

  // Start and stop status from the lines, cleared by disable
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      begin_noted <= 1'b0;
      halt_detected <= 1'b0;
    end else if (clock_enable) begin
      if (!module_enable) begin
        begin_noted <= 1'b0;
        halt_detected <= 1'b0;
      end else if (start_seen) begin
        begin_noted <= 1'b1;
        halt_detected <= 1'b0;
      end else if (stop_seen) begin
        halt_detected <= 1'b1;
        begin_noted <= 1'b0;
      end
    end
  end

  // Wake the sleeping processor on a completed byte or condition
  assign wake_request = sleep_mode && interrupt_enable && port_event_flag;
endmodule

// File: dv/i2cms_sequencer_chk.sv
// Port checker for the I2C master condition sequencer
`timescale 1ns/1ns
module i2cms_sequencer_chk
  import i2cms_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic module_enable,
  input wire logic acknowledge_value_bit,
  input wire logic buffer_write,
  input wire logic sleep_mode,
  input wire logic interrupt_enable,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic begin_cond_trigger,
  input wire logic restart_trigger,
  input wire logic halt_cond_trigger,
  input wire logic acknowledge_sequence_trigger,
  input wire logic [DATA_W-1:0] transfer_buffer,
  input wire logic buffer_full_flag,
  input wire logic port_event_flag,
  input wire logic collision_flag,
  input wire logic write_collide_flag,
  input wire logic begin_noted,
  input wire logic halt_detected,
  input wire logic wake_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic any_trig;
  assign any_trig = begin_cond_trigger | restart_trigger | halt_cond_trigger
    | acknowledge_sequence_trigger;
  full_on_write_a:
    assert property ($rose(buffer_full_flag) |-> $past(buffer_write))
    else $error("Buffer full rose without a write");
  write_refused_a:
    assert property (buffer_write && any_trig |=> write_collide_flag && $stable(transfer_buffer))
    else $error("Busy write not refused");
  cond_event_a:
    assert property (($fell(begin_cond_trigger) || $fell(restart_trigger)
      || $fell(acknowledge_sequence_trigger) || $fell(halt_cond_trigger))
      && module_enable && !collision_flag |-> port_event_flag)
    else $error("Sequence ended without event");
  start_lines_a:
    assert property ($fell(begin_cond_trigger) && module_enable && !collision_flag
      |-> scl_oe && sda_oe)
    else $error("Start did not leave both lines low");
  ack_value_a:
    assert property ($rose(acknowledge_sequence_trigger)
      |-> ##[1:2] scl_oe && (sda_oe != acknowledge_value_bit))
    else $error("Acknowledge value not placed");
  coll_release_a:
    assert property ($rose(collision_flag) |-> !scl_oe && !sda_oe && !buffer_full_flag && !any_trig)
    else $error("Collision did not release");
  disable_clear_a:
    assert property (!module_enable [*2] |-> !begin_noted && !halt_detected && !scl_oe && !sda_oe)
    else $error("Disabled module not cleared");
  sleep_wake_a:
    assert property (wake_request == (sleep_mode && interrupt_enable && port_event_flag))
    else $error("Wake request wrong");
  scl_hold_a:
    assert property (port_event_flag && scl_oe && !buffer_write && !any_trig && module_enable
      |=> scl_oe)
    else $error("Clock not held low while suspended");
  scl_high_a:
    assert property ($fell(scl_oe) |=> !scl_oe [*3])
    else $error("Clock high phase too short");
endmodule
bind i2cms_sequencer i2cms_sequencer_chk u_chk (.*);

// File: dv/i2cms_slave_model.sv
// Behavioural I2C slave that captures bytes and answers the acknowledge
`timescale 1ns/1ns
module i2cms_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_enable,
  output logic sda_pull,
  output logic [7:0] rx_byte
);
  int count = 0;
  logic [7:0] shift = 8'h00;
  initial sda_pull = 0;
  initial rx_byte = 8'h00;
  // Start or repeated start restarts the bit count
  always @(negedge sda) begin
    if (scl) begin
      count = 0;
    end
  end
  // Data bits are taken while the clock is high
  always @(posedge scl) begin
    if (count < 8) begin
      shift = {shift[6:0], sda};
    end
    count = count + 1;
  end
  // Acknowledge is pulled low across the ninth clock
  always @(negedge scl) begin
    if (count == 8) begin
      rx_byte = shift;
      sda_pull = ack_enable;
    end else begin
      sda_pull = 0;
    end
    if (count >= 9) begin
      count = 0;
    end
  end
endmodule

// File: dv/i2c_master_condition_sequencer_bench.sv
// Self-checking bench for the I2C master condition sequencer
`timescale 1ns/1ns
module i2c_master_condition_sequencer_bench;
  import i2cms_pkg::*;
  logic clock = 0, reset = 1, clock_enable = 1, module_enable = 0;
  logic [RATE_W-1:0] rate_reload_register = 7'h40;
  logic begin_cond_set = 0, restart_set = 0, halt_cond_set = 0, acknowledge_sequence_set = 0;
  logic acknowledge_value_bit = 0, buffer_write = 0, port_event_clear = 0, collision_clear = 0;
  logic write_collide_clear = 0, sleep_mode = 0, interrupt_enable = 0;
  logic [DATA_W-1:0] buffer_write_data = 8'h00, transfer_buffer, rx_byte;
  logic scl_out, scl_oe, sda_out, sda_oe, begin_cond_trigger, restart_trigger, halt_cond_trigger;
  logic acknowledge_sequence_trigger, buffer_full_flag, acknowledge_received_status;
  logic port_event_flag, collision_flag, write_collide_flag, begin_noted, halt_detected;
  logic wake_request, ack_enable = 1, force_low = 0, slave_pull;
  wire scl_in = !scl_oe;
  wire sda_in = !(sda_oe || slave_pull || force_low);
  int n_mismatch = 0, n_compared = 0, i;
  logic [DATA_W-1:0] sent_q[$];
  always #25 clock = !clock;
  i2cms_sequencer u_dut (.*);
  i2cms_slave_model u_slave (.scl(scl_in), .sda(sda_in), .ack_enable(ack_enable),
    .sda_pull(slave_pull), .rx_byte(rx_byte));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("Compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_done(input logic coll);
    int k;
    for (k = 0; k < 5000; k++) begin
      @(negedge clock);
      if (port_event_flag === 1 || (coll && collision_flag === 1)) break;
    end
    if (k == 5000) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  // Clears the sticky flags, then raises one request for a cycle
  task automatic op(input int kind, input logic [7:0] d);
    @(posedge clock);
    {port_event_clear, collision_clear, write_collide_clear} <= 3'h7;
    @(posedge clock);
    {port_event_clear, collision_clear, write_collide_clear} <= 3'h0;
    begin_cond_set <= kind == 0;
    restart_set <= kind == 1;
    acknowledge_sequence_set <= kind == 2;
    halt_cond_set <= kind == 3;
    buffer_write <= kind == 4;
    buffer_write_data <= d;
    @(posedge clock);
    {begin_cond_set, restart_set, acknowledge_sequence_set, halt_cond_set, buffer_write} <= 5'h00;
  endtask
  task automatic send(input logic [7:0] d, input logic a);
    ack_enable <= a;
    sent_q.push_back(d);
    op(4, d);
    @(negedge clock);
    check("buffer_full_flag", 8'h01, buffer_full_flag);
    check("transfer_buffer", d, transfer_buffer);
    wait_done(1);
    check("rx_byte", sent_q.pop_front(), rx_byte);
    check("acknowledge_received_status", !a, acknowledge_received_status);
    check("buffer_full_flag", 8'h00, buffer_full_flag);
    check("scl_oe", 8'h01, scl_oe);
  endtask
  initial begin
    i = $urandom(32'h00eb);
    @(posedge clock);
    rate_reload_register <= 7'h40 | 7'($urandom % 4);
    acknowledge_value_bit <= 1'($urandom);
    repeat (5) @(posedge clock);
    reset <= 0;
    module_enable <= 1;
    @(negedge clock);
    check("idle lines", 8'h00, {scl_out, sda_out, scl_oe, sda_oe, begin_noted, halt_detected});
    op(0, 8'h00);
    wait_done(0);
    check("begin_noted", 8'h01, begin_noted);
    check("start lines", 8'h03, {scl_oe, sda_oe});
    check("begin_cond_trigger", 8'h00, begin_cond_trigger);
    for (i = 0; i < 3; i++) send(8'($urandom), 1'($urandom));
    op(2, 8'h00);
    @(posedge clock);
    buffer_write <= 1;
    buffer_write_data <= 8'h5a;
    @(posedge clock);
    buffer_write <= 0;
    wait_done(0);
    check("write_collide_flag", 8'h01, write_collide_flag);
    check("ack sda_oe", !acknowledge_value_bit, sda_oe);
    check("ack end", 8'h02, {scl_oe, acknowledge_sequence_trigger});
    op(1, 8'h00);
    wait_done(0);
    check("restart end", 8'h01, {restart_trigger, scl_oe, sda_oe});
    send(8'ha5, 0);
    op(3, 8'h00);
    wait_done(0);
    check("halt_detected", 8'h01, halt_detected);
    check("stop end", 8'h00, {halt_cond_trigger, scl_oe, sda_oe, begin_noted});
    op(0, 8'h00);
    wait_done(0);
    @(posedge clock);
    force_low <= 1;
    op(4, 8'hff);
    wait_done(1);
    check("collision_flag", 8'h01, collision_flag);
    check("released", 8'h00, {scl_oe, sda_oe, buffer_full_flag});
    @(posedge clock);
    force_low <= 0;
    sleep_mode <= 1;
    interrupt_enable <= 1;
    wait_done(0);
    check("halt_detected", 8'h01, halt_detected);
    check("wake_request", 8'h01, wake_request);
    @(posedge clock);
    force_low <= 1;
    repeat (4) @(posedge clock);
    op(0, 8'h00);
    wait_done(1);
    check("start collision", 8'h08, {collision_flag, begin_cond_trigger, scl_oe, sda_oe});
    @(posedge clock);
    force_low <= 0;
    wait_done(0);
    check("begin_noted", 8'h00, begin_noted);
    @(posedge clock);
    module_enable <= 0;
    repeat (3) @(negedge clock);
    check("disabled status", 8'h00, {begin_noted, halt_detected});
    complete_run();
  end
endmodule
